// ---- src/ccl_pkg.sv ----
package ccl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          CCL_DATA_W     = 32;
  localparam logic [3:0]  CCL_OFS_CTRL   = 4'h0;
  localparam logic [3:0]  CCL_OFS_STAT   = 4'h4;
  localparam logic [3:0]  CCL_OFS_MASK   = 4'h8;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int          CCL_BIT_ON     = 15;
  localparam int          CCL_BIT_OE     = 14;
  localparam int          CCL_BIT_POL    = 13;
  localparam int          CCL_BIT_RES    = 8;
  localparam int          CCL_EV_HI      = 7;
  localparam int          CCL_EV_LO      = 6;
  localparam int          CCL_BIT_POS_INPUT_INTERNAL_REF_SEL   = 4;
  localparam int          CCL_NEG_HI     = 1;
  localparam int          CCL_NEG_LO     = 0;

  localparam logic [31:0] CCL_CTRL_RST   = 32'h0000_00C3;
  localparam logic [31:0] CCL_CTRL_WMASK = 32'h0000_E0D3;
  localparam logic [31:0] CCL_IRQ_BITS   = 32'h0000_0001;
  localparam logic [31:0] CCL_IRQ_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus answers and edge selection
  // ----------------------------------------------------------------
  localparam logic [1:0]  CCL_RESP_OKAY  = 2'b00;
  localparam logic [1:0]  CCL_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CCL_EV_OFF  = 2'b00,
    CCL_EV_RISE = 2'b01,
    CCL_EV_FALL = 2'b10,
    CCL_EV_BOTH = 2'b11
  } ccl_edge_t;

endpackage : ccl_pkg

// ---- src/ccl_evt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ccl_evt_if;
  logic       rawResult;
  logic       invert;
  logic       enable;
  logic [1:0] edgeSel;
  logic       result;
  logic       eventPulse;

  modport ctrl (output rawResult, output invert, output enable, output edgeSel,
                input result, input eventPulse);
  modport edet (input rawResult, input invert, input enable, input edgeSel,
                output result, output eventPulse);
endinterface : ccl_evt_if
`default_nettype wire

// ---- src/ccl_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccl_edge
  import ccl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic clkEn,
  input  wire logic rstN,
  // event path
  ccl_evt_if.edet   evt
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       prev_q;
  logic       prev_d;
  logic       res_q;
  logic       res_d;
  logic       pulse_q;
  logic       pulse_d;
  logic       polar;
  logic       hit;

  // ----------------------------------------------------------------
  // sync, polarity, edge detect
  // ----------------------------------------------------------------
  always_comb begin
    sync_d = {sync_q[0], evt.rawResult};
    polar  = sync_q[1] ^ evt.invert;
    prev_d = polar;
    case (ccl_edge_t'(evt.edgeSel))
      CCL_EV_RISE: hit = polar & ~prev_q;
      CCL_EV_FALL: hit = ~polar & prev_q;
      CCL_EV_BOTH: hit = polar ^ prev_q;
      default:     hit = 1'b0;
    endcase
    pulse_d = evt.enable & hit;
    res_d   = evt.enable & polar;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sync_q  <= 2'b00;
      prev_q  <= 1'b0;
      res_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (clkEn) begin
      sync_q  <= sync_d;
      prev_q  <= prev_d;
      res_q   <= res_d;
      pulse_q <= pulse_d;
    end
  end

  assign evt.result     = res_q;
  assign evt.eventPulse = pulse_q;

endmodule : ccl_edge
`default_nettype wire

// ---- src/ccl_top.sv ----
// What this block does
// - setting the enable bit 15 turns the comparator on, writable fields in strobed bytes take the written value
// - clearing the enable bit turns the comparator off, writable fields in strobed bytes take the written value
// - bit 14 set together with bit 15 drives the result on the output pin, else pin undriven
// - bit 13 set inverts the comparator result
// - bit 8 reads the current result, read only
// - bits 7-6 pick interrupt edge: both, falling, rising or none
// - inversion also feeds the edge detector, so the opposite edge fires
// - bit 4 picks ladder reference or first pin for the positive input
// - bits 1-0 pick fixed reference or pin d, c, b for negative input
// - unused control bits ignore writes and read as zero
`timescale 1ns/1ps
`default_nettype none
module ccl_top
  import ccl_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog comparator core
  input  wire logic              compRawResult,
  output logic                   compEnable,
  output logic                   posInputInternalRefSel,
  output logic [1:0]             negInputSelect,
  // result pin
  output logic                   resultPin,
  output logic                   resultPinOe,
  // interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 16) begin : gBadAddr
    $error("ccl_top: ADDR_W must lie in 4..16");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_q;
  logic [1:0] rstPipe_d;
  logic       rstSyncN;

  always_comb begin
    rstPipe_d = {rstPipe_q[0], 1'b1};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= 2'b00;
    end else if (clkEn) begin
      rstPipe_q <= rstPipe_d;
    end
  end

  assign rstSyncN = rstPipe_q[1];

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_q;
  logic [31:0]       ctrl_d;
  logic [31:0]       stat_q;
  logic [31:0]       stat_d;
  logic [31:0]       mask_q;
  logic [31:0]       mask_d;
  logic              awHeld_q;
  logic              awHeld_d;
  logic [ADDR_W-1:0] awAddr_q;
  logic [ADDR_W-1:0] awAddr_d;
  logic              wHeld_q;
  logic              wHeld_d;
  logic [31:0]       wData_q;
  logic [31:0]       wData_d;
  logic [3:0]        wStrb_q;
  logic [3:0]        wStrb_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              awTake;
  logic              wTake;
  logic              doWrite;
  logic              arTake;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic [31:0]       byteMask;
  logic [3:0]        wrWord;
  logic [3:0]        rdWord;
  logic [31:0]       ctrlView;
  logic              rdHit;
  logic              wrHit;
  logic [31:0]       irqSet;
  logic [31:0]       irqClr;
  logic              irq_q;
  logic              irq_d;

  // ----------------------------------------------------------------
  // edge detector
  // ----------------------------------------------------------------
  ccl_evt_if evtBus ();

  assign evtBus.rawResult = compRawResult;
  assign evtBus.invert    = ctrl_q[CCL_BIT_POL];
  assign evtBus.enable    = ctrl_q[CCL_BIT_ON];
  assign evtBus.edgeSel   = ctrl_q[CCL_EV_HI:CCL_EV_LO];

  ccl_edge uEdge (
    .clk   (core_clk),
    .clkEn (clkEn),
    .rstN  (rstSyncN),
    .evt   (evtBus.edet)
  );

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready  = ~wHeld_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    awTake   = s_axi_awvalid & s_axi_awready;
    wTake    = s_axi_wvalid & s_axi_wready;
    doWrite  = (awHeld_q | awTake) & (wHeld_q | wTake);
    wrAddr   = awHeld_q ? awAddr_q : s_axi_awaddr;
    wrData   = wHeld_q ? wData_q : s_axi_wdata;
    wrStrb   = wHeld_q ? wStrb_q : s_axi_wstrb;
    wrWord   = {wrAddr[3:2], 2'b00};
    wrHit    = (wrAddr[ADDR_W-1:2] <= (ADDR_W-2)'(2)) && (wrAddr[1:0] == 2'b00);
    awHeld_d = (awHeld_q | awTake) & ~doWrite;
    wHeld_d  = (wHeld_q | wTake) & ~doWrite;
    awAddr_d = awTake ? s_axi_awaddr : awAddr_q;
    wData_d  = wTake ? s_axi_wdata : wData_q;
    wStrb_d  = wTake ? s_axi_wstrb : wStrb_q;
    bvalid_d = doWrite | (bvalid_q & ~s_axi_bready);
    bresp_d  = bresp_q;
    if (doWrite) begin
      bresp_d = wrHit ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
    end
    for (int i = 0; i < 4; i++) begin
      byteMask[8*i +: 8] = {8{wrStrb[i]}};
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= CCL_RESP_OKAY;
    end else if (clkEn) begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q  <= wHeld_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
    end
  end

  // ----------------------------------------------------------------
  // control, status and mask registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    irqClr = 32'h0000_0000;
    irqSet = {31'h0000_0000, evtBus.eventPulse} & CCL_IRQ_BITS;
    if (doWrite && wrHit && wrWord == CCL_OFS_CTRL) begin
      // byte-lane merge: on/off rewrites every writable field in the strobed bytes
      ctrl_d = (ctrl_q & ~(byteMask & CCL_CTRL_WMASK))
             | (wrData & byteMask & CCL_CTRL_WMASK);
    end
    if (doWrite && wrHit && wrWord == CCL_OFS_MASK) begin
      mask_d = (mask_q & ~(byteMask & CCL_IRQ_BITS)) | (wrData & byteMask & CCL_IRQ_BITS);
    end
    if (doWrite && wrHit && wrWord == CCL_OFS_STAT) begin
      irqClr = wrData & byteMask & CCL_IRQ_BITS;
    end
    // new event beats a same-cycle clear
    stat_d = (stat_q & ~irqClr) | irqSet;
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrl_q <= CCL_CTRL_RST;
      stat_q <= CCL_IRQ_RST;
      mask_q <= CCL_IRQ_RST;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // built from next values so the level lines up with the status bit
  always_comb begin
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    arTake   = s_axi_arvalid & s_axi_arready;
    rdWord   = {s_axi_araddr[3:2], 2'b00};
    rdHit    = (s_axi_araddr[ADDR_W-1:2] <= (ADDR_W-2)'(2)) && (s_axi_araddr[1:0] == 2'b00);
    ctrlView = ctrl_q & CCL_CTRL_WMASK;
    ctrlView[CCL_BIT_RES] = evtBus.result;
    rvalid_d = arTake | (rvalid_q & ~s_axi_rready);
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (arTake) begin
      rresp_d = rdHit ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
      case (rdWord)
        CCL_OFS_CTRL: rdata_d = rdHit ? ctrlView : 32'h0000_0000;
        CCL_OFS_STAT: rdata_d = rdHit ? stat_q : 32'h0000_0000;
        CCL_OFS_MASK: rdata_d = rdHit ? mask_q : 32'h0000_0000;
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= CCL_RESP_OKAY;
    end else if (clkEn) begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // analog controls, pin and interrupt
  // ----------------------------------------------------------------
  assign compEnable             = ctrl_q[CCL_BIT_ON];
  assign posInputInternalRefSel = ctrl_q[CCL_BIT_POS_INPUT_INTERNAL_REF_SEL];
  assign negInputSelect         = ctrl_q[CCL_NEG_HI:CCL_NEG_LO];
  assign resultPin              = evtBus.result;
  assign resultPinOe            = ctrl_q[CCL_BIT_ON] & ctrl_q[CCL_BIT_OE];
  assign irq                    = irq_q;

endmodule : ccl_top
`default_nettype wire

// ---- sim/ccl_comp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccl_comp_model (
  // selection from the block
  input  wire logic            compEnable,
  input  wire logic            posSel,
  input  wire logic [1:0]      negSel,
  // levels: pos pin, ladder, fixed, pin d, pin c, pin b
  input  wire logic [5:0][7:0] lvl,
  // raw comparator output
  output logic                 rawOut
);
  logic [7:0] posLvl;
  logic [7:0] negLvl;

  always_comb begin
    posLvl = posSel ? lvl[1] : lvl[0];
    negLvl = lvl[3'd2 + {1'b0, negSel}];
    rawOut = compEnable && (posLvl > negLvl);
  end
endmodule : ccl_comp_model
`default_nettype wire

// ---- sim/ccl_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccl_top_chk (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // bus
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // comparator and pin
  input  wire logic        compRawResult,
  input  wire logic        compEnable,
  input  wire logic        resultPin,
  input  wire logic        resultPinOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_quiet;
    (compEnable && $stable(compRawResult) && !(s_axi_wvalid && s_axi_wready) &&
     !(s_axi_awvalid && s_axi_awready))[*4];
  endsequence

  a_oe_needs_on: assert property (resultPinOe |-> compEnable)
    else $error("pin driven while module off");
  a_pin_off: assert property ((!compEnable)[*2] |-> !resultPin)
    else $error("result pin high while off");
  a_pin_steady: assert property (s_quiet |-> $stable(resultPin))
    else $error("result moved without input change");
  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_unused_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
    s_axi_rdata[12:9] == 4'h0 && !s_axi_rdata[5] && s_axi_rdata[3:2] == 2'b00)
    else $error("unused bit read as one");
endmodule : ccl_top_chk
`default_nettype wire

bind ccl_top ccl_top_chk i_chk (.core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .compRawResult, .compEnable,
  .resultPin, .resultPinOe);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import ccl_pkg::*;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic compRawResult, compEnable, posInputInternalRefSel, resultPin, resultPinOe;
  logic [3:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [1:0]      s_axi_bresp, s_axi_rresp, negInputSelect;
  logic [5:0][7:0] lvl;
  int              n_mismatch, checks, guard;

  ccl_top i_dut (.core_clk, .rst_n, .clkEn(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .compRawResult, .compEnable, .posInputInternalRefSel,
    .negInputSelect, .resultPin, .resultPinOe, .irq);
  ccl_comp_model i_comp (.compEnable, .posSel(posInputInternalRefSel), .negSel(negInputSelect),
    .lvl, .rawOut(compRawResult));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic tick();
    @(posedge core_clk);
    guard++;
    if (guard > 500) begin
      n_mismatch++;
      $display("Error %0t: wait limit reached", $time);
      final_report();
    end
  endtask : tick

  task automatic wait_cyc(input int n);
    guard = 0;
    repeat (n) tick();
  endtask : wait_cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    guard = 0;
    tick();
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick();
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bresp, CCL_RESP_OKAY)
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    guard = 0;
    tick();
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick();
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, CCL_RESP_OKAY)
  endtask : rd_chk

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(CCL_OFS_CTRL, 32'h0000_00C3);
    rd_chk(CCL_OFS_STAT, 32'h0000_0000);
    rd_chk(CCL_OFS_MASK, 32'h0000_0000);
    rd(4'hC, d, r);
    `CHK(r, CCL_RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    `CHK(irq, 1'b0)
  endtask : t_reset

  task automatic t_ctrl();
    lvl <= {8'd150, 8'd50, 8'd150, 8'd50, 8'd10, 8'd100};
    wr(CCL_OFS_CTRL, 32'hFFFF_FFFF);
    wait_cyc(6);
    rd_chk(CCL_OFS_CTRL, 32'h0000_E1D3);
    `CHK({compEnable, resultPinOe, resultPin}, 3'b111)
    `CHK({posInputInternalRefSel, negInputSelect}, 3'b111)
    wr(CCL_OFS_CTRL, 32'h0000_60D3);
    wait_cyc(2);
    rd_chk(CCL_OFS_CTRL, 32'h0000_60D3);
    `CHK({compEnable, resultPinOe, resultPin}, 3'b000)
    wr(CCL_OFS_CTRL, 32'h0000_E0D3);
    wait_cyc(6);
    rd_chk(CCL_OFS_CTRL, 32'h0000_E1D3);
  endtask : t_ctrl

  task automatic t_mux();
    int          neg [4] = '{50, 150, 50, 150};
    logic [31:0] d;
    lvl <= {8'd150, 8'd50, 8'd150, 8'd50, 8'd200, 8'd100};
    for (int c = 0; c < 2; c++) begin
      for (int n = 0; n < 4; n++) begin
        d = 32'h0000_8000;
        d[CCL_BIT_POS_INPUT_INTERNAL_REF_SEL] = c[0];
        d[1:0] = n[1:0];
        wr(CCL_OFS_CTRL, d);
        wait_cyc(6);
        d[CCL_BIT_RES] = ((c == 1 ? 200 : 100) > neg[n]);
        rd_chk(CCL_OFS_CTRL, d);
        `CHK(negInputSelect, n[1:0])
      end
    end
  endtask : t_mux

  task automatic t_irq();
    logic rf, ff;
    for (int ev = 0; ev < 4; ev++) begin
      for (int p = 0; p < 2; p++) begin
        lvl[0] <= 8'd0;
        wr(CCL_OFS_CTRL, 32'h0000_8000 | 32'(p << 13) | 32'(ev << 6));
        wr(CCL_OFS_MASK, 32'h0000_0001);
        wait_cyc(6);
        wr(CCL_OFS_STAT, 32'h0000_0001);
        rf = (ev == 3) || (ev == (p == 1 ? 2 : 1));
        ff = (ev == 3) || (ev == (p == 1 ? 1 : 2));
        lvl[0] <= 8'd100;
        wait_cyc(8);
        rd_chk(CCL_OFS_STAT, {31'h0, rf});
        `CHK(irq, rf)
        wr(CCL_OFS_STAT, 32'h0000_0001);
        lvl[0] <= 8'd0;
        wait_cyc(8);
        rd_chk(CCL_OFS_STAT, {31'h0, ff});
        `CHK(irq, ff)
        wr(CCL_OFS_STAT, 32'h0000_0001);
      end
    end
    wr(CCL_OFS_MASK, 32'h0000_0000);
    lvl[0] <= 8'd100;
    wait_cyc(8);
    rd_chk(CCL_OFS_STAT, 32'h0000_0001);
    `CHK(irq, 1'b0)
    wr(CCL_OFS_STAT, 32'h0000_0001);
    rd_chk(CCL_OFS_STAT, 32'h0000_0000);
  endtask : t_irq

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; lvl = '0;
    n_mismatch = 0; checks = 0; guard = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_cyc(3);
    t_reset();
    t_ctrl();
    t_mux();
    t_irq();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
